// ===== include/serial0_pkg.sv
// Purpose: Shared constants and types for the serial port control block
// Assumes: Register word index times four gives the byte address
// Notes: Indices follow the special-function register numbers
package serial0_pkg;

    localparam int ADDR_W = 12;

    // Register word indices
    localparam logic [7:0] IDX_DIV_LOW = 8'hDC;
    localparam logic [7:0] IDX_MODE_A = 8'hDD;
    localparam logic [7:0] IDX_MODE_B = 8'hDE;
    localparam logic [7:0] IDX_STATUS = 8'hDF;
    localparam logic [7:0] IDX_IRQ_B = 8'hE1;
    localparam logic [7:0] IDX_DATA = 8'hE2;
    localparam logic [7:0] IDX_BAUD_EXT = 8'hF0;

    // Mode control b fields
    localparam int MB_EXTRA_LSB = 4;
    localparam int MB_TX_IRQ_ON = 3;
    localparam int MB_RX_IRQ_ON = 2;
    localparam int MB_HIGH_LSB = 0;

    // Status fields
    localparam int ST_RX_NINTH = 6;
    localparam int ST_TX_NINTH = 5;
    localparam int ST_TX_EMPTY = 4;
    localparam int ST_RX_FULL = 3;
    localparam int ST_OVERRUN = 2;
    localparam int ST_FRAMING = 1;
    localparam int ST_PARITY = 0;

    localparam int IRQB_SERIAL0 = 2;
    localparam int BEXT_SELECT = 0;

    // Reset values
    localparam logic [7:0] MODE_A_RST = 8'h00;
    localparam logic [7:0] MODE_B_RST = 8'h0C;
    localparam logic [7:0] DIV_LOW_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;

    // Oversampling: sixteen ticks per bit, centre at the eighth
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_HALF = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic spare;
        logic port_module_on;
        logic rx_on;
        logic multi_on;
        logic two_stop;
        logic nine_bit;
        logic parity_on;
        logic parity_odd;
    } mode_a_s;

    typedef enum logic [2:0] {
        F_IDLE = 3'b000,
        F_START = 3'b001,
        F_DATA = 3'b010,
        F_NINTH = 3'b011,
        F_STOP = 3'b100
    } frame_state_e;

endpackage : serial0_pkg

// ===== logic/serial0_port.sv
// Purpose: One asynchronous serial port with its control and status registers
// Assumes: rx_line synchronous to aclk; AXI4-Lite slave, one access at a time
// Notes: Frames are start, data LSB first, optional ninth or parity, stop
//
// What this block does
// - Module enable bit 6 gates divider, transmitter and receiver
// - Receiver enable bit 5 gates reception
// - Bit 4 turns on multiprocessor mode
// - Bit 3 chooses two or one stop
// - Bit 2 chooses nine or eight data
// - Bit 1 enables parity generate and check
// - Bit 0 chooses odd or even parity
// - Control b bits 5:4 extend divisor
// - Control b bits 1:0 divisor high bits
// - Empty and full irq enables, reset 1
// - Status bit 6 received ninth bit, read-only
// - Status bit 5 ninth tx bit, locked by parity
// - Status bit 4 set when tx empties
// - Status bit 3 set when rx fills
// - Status bit 2 overrun, new character dropped
// - Status bit 1 framing error on bad stop
// - Status bit 0 parity mismatch on receive
// - Flags clear by writing zero only
// - Pending request sets irq flag bit 2
// - Data port reads rx, writes tx buffer
// - Divisor is high bits over low byte
// - Zero divisor stops, else clock/(16*divisor)
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module serial0_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [serial0_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [serial0_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_line,
    output logic tx_line,
    output logic serial0_irq_pending
);
    import serial0_pkg::*;

    mode_a_s mode_a_q;
    logic [7:0] mode_b_q, divisor_low_byte_q, rx_buf_q, tx_buf_q;
    logic divisor_extension_select_q;
    logic tx_empty_q, rx_full_q, overrun_q, framing_q, parity_err_q, rx_ninth_q, tx_ninth_q;
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] aw_addr_q, ar_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic wr_fire, wr_hit, wr_lane;
    logic [7:0] wr_idx, rd_idx, rd_byte;
    logic rd_hit;
    logic [11:0] divisor, div_cnt_q;
    logic tick_q;
    logic tx_pending_q, tx_load, tx_par;
    frame_state_e tx_state_q, rx_state_q;
    logic [3:0] tx_os_q, rx_os_q;
    logic [2:0] tx_bit_q, rx_bit_q;
    logic tx_stop_q;
    logic [7:0] tx_shift_q, rx_shift_q;
    logic tx_ninth_sent_q, rx_ninth_got_q;
    logic rx_prev_q, ar_have_q, rx_run;
    logic rx_done, rx_keep, rx_stop_bad, rx_par_bad, irq_evt;
    logic ninth_on, wr_status, wr_data, wr_irq_b;

    // Write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx = aw_addr_q[9:2];
    assign wr_hit = (aw_addr_q[ADDR_W-1:10] == '0) && (wr_idx == IDX_DIV_LOW || wr_idx == IDX_MODE_A
        || wr_idx == IDX_MODE_B || wr_idx == IDX_STATUS || wr_idx == IDX_IRQ_B || wr_idx == IDX_DATA
        || wr_idx == IDX_BAUD_EXT);
    assign wr_lane = wr_fire && wr_hit && w_lane_q;
    assign wr_status = wr_lane && wr_idx == IDX_STATUS;
    assign wr_data = wr_lane && wr_idx == IDX_DATA;
    assign wr_irq_b = wr_lane && wr_idx == IDX_IRQ_B;

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_a_q <= mode_a_s'(MODE_A_RST);
            mode_b_q <= MODE_B_RST;
            divisor_low_byte_q <= DIV_LOW_RST;
            divisor_extension_select_q <= 1'b0;
        end else if (wr_lane) begin
            if (wr_idx == IDX_MODE_A) begin
                mode_a_q <= mode_a_s'({1'b0, w_data_q[6:0]});
            end
            if (wr_idx == IDX_MODE_B) begin
                mode_b_q <= {2'b00, w_data_q[5:0]};
            end
            if (wr_idx == IDX_DIV_LOW) begin
                divisor_low_byte_q <= w_data_q;
            end
            if (wr_idx == IDX_BAUD_EXT) begin
                divisor_extension_select_q <= w_data_q[BEXT_SELECT];
            end
        end
    end

    // Read channel
    assign rd_idx = ar_addr_q[9:2];
    always_comb begin
        rd_hit = (ar_addr_q[ADDR_W-1:10] == '0);
        rd_byte = 8'h00;
        unique case (rd_idx)
            IDX_DIV_LOW: rd_byte = divisor_low_byte_q;
            IDX_MODE_A: rd_byte = mode_a_q;
            IDX_MODE_B: rd_byte = mode_b_q;
            IDX_STATUS: rd_byte = {1'b0, rx_ninth_q, tx_ninth_q, tx_empty_q, rx_full_q, overrun_q,
                framing_q, parity_err_q};
            IDX_IRQ_B: rd_byte = {5'h00, serial0_irq_pending, 2'h0};
            IDX_DATA: rd_byte = rx_buf_q;
            IDX_BAUD_EXT: rd_byte = {7'h00, divisor_extension_select_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Address taken, answer one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            ar_addr_q <= '0;
            ar_have_q <= 1'b0;
        end else begin
            s_axi_arready <= !ar_have_q && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                ar_have_q <= 1'b1;
                ar_addr_q <= s_axi_araddr;
            end
            if (ar_have_q && !s_axi_rvalid) begin
                ar_have_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign ninth_on = mode_a_q.nine_bit || mode_a_q.parity_on;

    assign divisor = divisor_extension_select_q
        ? {mode_b_q[MB_EXTRA_LSB+:2], mode_b_q[MB_HIGH_LSB+:2], divisor_low_byte_q}
        : {2'b00, mode_b_q[MB_HIGH_LSB+:2], divisor_low_byte_q};

    // Sixteen ticks per bit, none at zero
    always_ff @(posedge aclk) begin
        if (!aresetn || !mode_a_q.port_module_on || divisor == 12'h000) begin
            div_cnt_q <= 12'h000;
            tick_q <= 1'b0;
        end else if (div_cnt_q >= divisor - 12'h001) begin
            div_cnt_q <= 12'h000;
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 12'h001;
            tick_q <= 1'b0;
        end
    end

    assign tx_par = mode_a_q.parity_odd ? ~^tx_buf_q : ^tx_buf_q;
    assign tx_load = tick_q && mode_a_q.port_module_on && tx_state_q == F_IDLE && tx_pending_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pending_q <= 1'b0;
            tx_buf_q <= DATA_RST;
        end else if (wr_data) begin
            tx_pending_q <= 1'b1;
            tx_buf_q <= w_data_q;
        end else if (tx_load) begin
            tx_pending_q <= 1'b0;
        end
    end

    // Start, data LSB first, ninth, stop
    always_ff @(posedge aclk) begin
        if (!aresetn || !mode_a_q.port_module_on) begin
            tx_state_q <= F_IDLE;
            tx_line <= 1'b1;
            tx_os_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_stop_q <= 1'b0;
            tx_shift_q <= 8'h00;
            tx_ninth_sent_q <= 1'b0;
        end else if (tick_q) begin
            tx_os_q <= tx_os_q + 4'h1;
            unique case (tx_state_q)
                F_IDLE: begin
                    tx_os_q <= 4'h0;
                    if (tx_load) begin
                        tx_state_q <= F_START;
                        tx_line <= 1'b0;
                        tx_shift_q <= tx_buf_q;
                        tx_ninth_sent_q <= mode_a_q.parity_on ? tx_par : tx_ninth_q;
                    end
                end
                F_START: begin
                    if (tx_os_q == OS_LAST) begin
                        tx_state_q <= F_DATA;
                        tx_bit_q <= 3'h0;
                        tx_line <= tx_shift_q[0];
                    end
                end
                F_DATA: begin
                    if (tx_os_q == OS_LAST && tx_bit_q != DATA_LAST) begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                        tx_line <= tx_shift_q[tx_bit_q + 3'h1];
                    end else if (tx_os_q == OS_LAST && ninth_on) begin
                        tx_state_q <= F_NINTH;
                        tx_line <= tx_ninth_sent_q;
                    end else if (tx_os_q == OS_LAST) begin
                        tx_state_q <= F_STOP;
                        tx_stop_q <= 1'b0;
                        tx_line <= 1'b1;
                    end
                end
                F_NINTH: begin
                    if (tx_os_q == OS_LAST) begin
                        tx_state_q <= F_STOP;
                        tx_stop_q <= 1'b0;
                        tx_line <= 1'b1;
                    end
                end
                F_STOP: begin
                    if (tx_os_q == OS_LAST && mode_a_q.two_stop && !tx_stop_q) begin
                        tx_stop_q <= 1'b1;
                    end else if (tx_os_q == OS_LAST) begin
                        tx_state_q <= F_IDLE;
                    end
                end
                default: begin
                    tx_state_q <= F_IDLE;
                    tx_line <= 1'b1;
                end
            endcase
        end
    end

    assign rx_run = aresetn && mode_a_q.port_module_on && mode_a_q.rx_on;

    // Idle level after reset, no false start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_line;
        end
    end

    always_ff @(posedge aclk) begin
        if (!rx_run) begin
            rx_state_q <= F_IDLE;
            rx_os_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_ninth_got_q <= 1'b0;
        end else if (rx_state_q == F_IDLE) begin
            rx_os_q <= 4'h0;
            if (rx_prev_q && !rx_line) begin
                rx_state_q <= F_START;
            end
        end else if (tick_q) begin
            rx_os_q <= rx_os_q + 4'h1;
            unique case (rx_state_q)
                F_START: begin
                    if (rx_os_q == OS_HALF && rx_line) begin
                        rx_state_q <= F_IDLE;
                    end else if (rx_os_q == OS_HALF) begin
                        rx_os_q <= 4'h0;
                        rx_bit_q <= 3'h0;
                        rx_state_q <= F_DATA;
                    end
                end
                F_DATA: begin
                    if (rx_os_q == OS_LAST) begin
                        rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == DATA_LAST) begin
                            rx_state_q <= ninth_on ? F_NINTH : F_STOP;
                        end
                    end
                end
                F_NINTH: begin
                    if (rx_os_q == OS_LAST) begin
                        rx_ninth_got_q <= rx_line;
                        rx_state_q <= F_STOP;
                    end
                end
                F_STOP: begin
                    if (rx_os_q == OS_LAST) begin
                        rx_state_q <= F_IDLE;
                    end
                end
                default: rx_state_q <= F_IDLE;
            endcase
        end
    end

    assign rx_done = rx_run && tick_q && rx_state_q == F_STOP && rx_os_q == OS_LAST;
    assign rx_stop_bad = !rx_line;
    assign rx_par_bad = mode_a_q.parity_on && ((^{rx_shift_q, rx_ninth_got_q}) != mode_a_q.parity_odd);
    // Multiprocessor drops nine-bit frames with ninth low
    assign rx_keep = !(mode_a_q.multi_on && mode_a_q.nine_bit && !rx_ninth_got_q);

    // Flags clear on written zero, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_empty_q <= 1'b0;
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
            framing_q <= 1'b0;
            parity_err_q <= 1'b0;
            rx_ninth_q <= 1'b0;
            tx_ninth_q <= 1'b0;
            rx_buf_q <= DATA_RST;
        end else begin
            if (tx_load) begin
                tx_empty_q <= 1'b1;
            end else if (wr_status && !w_data_q[ST_TX_EMPTY]) begin
                tx_empty_q <= 1'b0;
            end
            if (rx_done && rx_keep && !rx_full_q) begin
                rx_full_q <= 1'b1;
                rx_buf_q <= rx_shift_q;
                rx_ninth_q <= rx_ninth_got_q;
            end else if (wr_status && !w_data_q[ST_RX_FULL]) begin
                rx_full_q <= 1'b0;
            end
            if (rx_done && rx_keep && rx_full_q) begin
                overrun_q <= 1'b1;
            end else if (wr_status && !w_data_q[ST_OVERRUN]) begin
                overrun_q <= 1'b0;
            end
            if (rx_done && rx_stop_bad) begin
                framing_q <= 1'b1;
            end else if (wr_status && !w_data_q[ST_FRAMING]) begin
                framing_q <= 1'b0;
            end
            if (rx_done && rx_par_bad) begin
                parity_err_q <= 1'b1;
            end else if (wr_status && !w_data_q[ST_PARITY]) begin
                parity_err_q <= 1'b0;
            end
            if (wr_status && !mode_a_q.parity_on) begin
                tx_ninth_q <= w_data_q[ST_TX_NINTH];
            end
        end
    end

    // Enabled events raise the pending flag
    assign irq_evt = (tx_load && mode_b_q[MB_TX_IRQ_ON])
        || (rx_done && rx_keep && !rx_full_q && mode_b_q[MB_RX_IRQ_ON]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial0_irq_pending <= 1'b0;
        end else if (irq_evt) begin
            serial0_irq_pending <= 1'b1;
        end else if (wr_irq_b && !w_data_q[IRQB_SERIAL0]) begin
            serial0_irq_pending <= 1'b0;
        end
    end

endmodule : serial0_port
`default_nettype wire

// ===== test/serial0_peer.sv
// Purpose: Far-end serial transmitter model
// Assumes: Bit time in whole clocks
// Notes: Line idles high outside frames
`timescale 1ns/1ps
`default_nettype none
module serial0_peer #(
    parameter int BIT = 32
) (
    input wire logic aclk,
    input wire logic tx_line,
    output logic rx_line
);
    initial rx_line = 1'h1;
    task automatic send(input logic [9:0] v, input int n);
        rx_line <= 1'h0;
        for (int i = 0; i <= n; i++) begin
            repeat (BIT) @(posedge aclk);
            rx_line <= i == n | v[i];
        end
        repeat (BIT) @(posedge aclk);
    endtask : send
    // mid-bit samples of the block's frame
    task automatic catch(output logic [9:0] v, input int n);
        v = 10'h000;
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            repeat (BIT) @(posedge aclk);
            v[i] = tx_line;
        end
    endtask : catch
endmodule : serial0_peer
`default_nettype wire

// ===== test/serial0_port_properties.sv
// Purpose: Port properties of the serial port
// Assumes: Divisor of two or more
// Notes: Bound into the serial port
`timescale 1ns/1ps
`default_nettype none
module serial0_port_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_line,
    input wire logic serial0_irq_pending
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_tx_idle: assert property ($rose(aresetn) |-> tx_line [*4]) else $error("tx busy");
    a_irq_quiet: assert property ($rose(aresetn) |-> !serial0_irq_pending [*4]) else $error("irq");
    a_low_bit: assert property ($fell(tx_line) |-> !tx_line [*8]) else $error("short low");
    a_high_bit: assert property ($rose(tx_line) |-> tx_line [*8]) else $error("short high");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
    a_no_rdata: assert property ($rose(aresetn) |-> !s_axi_rvalid [*2]) else $error("early r");
    a_no_bresp: assert property ($rose(aresetn) |-> !s_axi_bvalid [*2]) else $error("early b");
endmodule : serial0_port_properties
bind serial0_port serial0_port_properties u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready, .tx_line, .serial0_irq_pending);
`default_nettype wire

// ===== test/serial0_port_tb.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Divisor two, 32 clocks a bit
// Notes: Peer drives the receive line
`timescale 1ns/1ps
`default_nettype none
module serial0_port_tb;
    import serial0_pkg::*;
    logic aclk = '0, aresetn = '0, awv = '0, wv = '0, br = '0, arv = '0, rr = '0;
    logic awr, wrd, bv, arr, rv, tx, rx, irq;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic [1:0] bre, rre;
    int failures = 0, num_checks = 0, cyc = 0;
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (++cyc == 20000) begin failures++; give_verdict(); end
    serial0_port u_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .rx_line(rx),
        .tx_line(tx), .serial0_irq_pending(irq));
    serial0_peer u_peer (.aclk, .tx_line(tx), .rx_line(rx));
    task automatic give_verdict();
        if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [9:0] g, e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, d);
        @(posedge aclk);
        {awa, wd, awv, wv, br} <= {ADDR_W'({i, 2'h0}), 24'h0, d, 3'h7};
        do begin
            @(posedge aclk);
            {awv, wv} <= {awv & ~awr, wv & ~wrd};
        end while (awv & ~awr | wv & ~wrd | !bv);
        br <= 1'h0;
    endtask : wr
    task automatic rc(input logic [7:0] i, e, m);
        @(posedge aclk);
        {ara, arv, rr} <= {ADDR_W'({i, 2'h0}), 2'h3};
        do begin
            @(posedge aclk);
            arv <= arv & ~arr;
        end while (!rv);
        rr <= 1'h0;
        chk({rre, rd[7:0] & m}, {(i == 8'h00) ? RESP_SLVERR : RESP_OKAY, e});
    endtask : rc
    task automatic t_regs();
        rc(IDX_MODE_B, 8'h0C, 8'h3F);
        rc(IDX_DATA, 8'hFF, 8'hFF);
        rc(8'h00, 8'h00, 8'h00);
    endtask : t_regs
    task automatic t_tx();
        logic [9:0] got;
        wr(IDX_DIV_LOW, 8'h02);
        wr(IDX_MODE_A, 8'h60);
        fork
            u_peer.catch(got, 9);
            wr(IDX_DATA, 8'hA5);
        join
        chk(got, 10'h1A5);
        // Let the stop bit finish
        repeat (100) @(posedge aclk);
        rc(IDX_STATUS, 8'h10, 8'h7F);
        chk({9'h0, irq}, 10'h001);
        wr(IDX_STATUS, 8'h1F);
        rc(IDX_STATUS, 8'h10, 8'h7F);
        wr(IDX_IRQ_B, 8'h00);
        rc(IDX_IRQ_B, 8'h00, 8'h04);
        wr(IDX_STATUS, 8'h3F);
        rc(IDX_STATUS, 8'h30, 8'h7F);
    endtask : t_tx
    task automatic t_rx();
        wr(IDX_STATUS, 8'h00);
        u_peer.send(10'h13C, 9);
        rc(IDX_STATUS, 8'h08, 8'h1F);
        u_peer.send(10'h155, 9);
        rc(IDX_STATUS, 8'h0C, 8'h1F);
        rc(IDX_DATA, 8'h3C, 8'hFF);
        wr(IDX_STATUS, 8'h00);
        u_peer.send(10'h011, 9);
        rc(IDX_STATUS, 8'h02, 8'h02);
        wr(IDX_MODE_A, 8'h63);
        u_peer.send(10'h301, 10);
        rc(IDX_STATUS, 8'h01, 8'h01);
    endtask : t_rx
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_tx();
        t_rx();
        give_verdict();
    end
endmodule : serial0_port_tb
`default_nettype wire
